// ---- rtl/rsc_clock_loss_detector.sv ----
/*
  one-shot that times out when the monitored system clock level stops toggling.
  assumes sysClkMon is a sampled copy of the system clock, synchronous to clk.
*/
`timescale 1ns/1ps
module rsc_clock_loss_detector
  import rsc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // monitor
  input  wire logic enable,
  input  wire logic sysClkMon,
  output logic      timeout
);

  logic                  prevLevel_q;
  logic [CLK_LOSS_W-1:0] count_q;
  logic                  timeout_q;
  wire                   levelChange = sysClkMon ^ prevLevel_q;
  wire                   atLimit     = (count_q == CLK_LOSS_CYCLES);

  // ****************************************
  // stuck level counter
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prevLevel_q <= 1'b0;
      count_q     <= '0;
      timeout_q   <= 1'b0;
    end
    else
    begin
      prevLevel_q <= sysClkMon;
      if (!enable || levelChange)
        count_q <= '0;
      else if (!atLimit)
        count_q <= count_q + CLK_LOSS_W'(1);
      timeout_q <= enable && atLimit && !levelChange;
    end
  end

  assign timeout = timeout_q;

endmodule

// ---- rtl/rsc_pkg.sv ----
/*
  constants, field positions and state type of the reset source controller.
  assumes a single 25 MHz clock shared by every file of the block.
*/
package rsc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] RSC_CAUSE_ENABLE_ADDR = 8'hEF;

  localparam int BIT_PIN   = 0;
  localparam int BIT_POR   = 1;
  localparam int BIT_MCD   = 2;
  localparam int BIT_WDT   = 3;
  localparam int BIT_SW    = 4;
  localparam int BIT_CMP   = 5;
  localparam int BIT_FLASH = 6;
  localparam int BIT_RTC   = 7;

  localparam int          RSC_REG_W      = 8;
  localparam logic [7:0]  FLAGS_POWER_ON = 8'h02;
  localparam logic [7:0]  FLAGS_NONE     = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_PERIOD_NS    = 40;
  localparam int          CLK_LOSS_TIME_US = 100;
  localparam int          CLK_LOSS_W       = 12;
  localparam logic [11:0] CLK_LOSS_CYCLES  =
    12'((CLK_LOSS_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [3:0]  WDT_CLK_DIV       = 4'hC;
  localparam logic [3:0]  RESET_HOLD_CYCLES = 4'h4;
  localparam logic [3:0]  CNT_ZERO          = 4'h0;
  localparam logic [3:0]  CNT_ONE           = 4'h1;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic {RSC_RUN, RSC_HOLD} rsc_state_t;

endpackage

// ---- rtl/rsc_reset_source_controller.sv ----
/*
  reset source controller: gathers reset requests, holds the system in reset,
  records the cause in the cause and enable register at its documented address.
  assumes all inputs are synchronous to clk; resetn is the power-on reset.
*/
//
// Contract
// - pin low puts device in reset, also in suspend or sleep.
// - leaving a pin reset sets the pin flag, bit 0.
// - enabled clock loss detector resets after clock stuck over 100 us.
// - bit 2 reads clock loss cause; writing sets detector enable.
// - clock loss reset masked in low power; enable kept and restored.
// - internal resets never drive the reset pin.
// - bit 5 write enables comparator reset; reads comparator cause.
// - enabled comparator holds reset while plus input below minus.
// - comparator reset works in low power only with wake-up enabled.
// - after any reset the watchdog is enabled, ticked at clock over 12.
// - watchdog overflow resets and sets read-only bit 3.
// - watchdog reset masked in low power; enable restored on exit.
// - five illegal flash access cases each cause a flash reset.
// - flash reset sets read-only flash fault bit 6.
// - timekeeper resets on slow oscillator or alarm match when enabled.
// - bit 7 enables timekeeper reset, reads its cause, works in low power.
// - writing 1 to bit 4 forces reset; bit 4 then reads 1.
// - bit 1 enables supply monitor reset; reads 1 after power resets.
// - when bit 1 reads 1, other bits are indeterminate.
// - enabling supply monitor reset before it is stable may reset.
// - read-modify-write on the register has no side effects; code keeps written-back flag bits as enables, and a 1 in bit 4 forces reset.
`timescale 1ns/1ps
module rsc_reset_source_controller
  import rsc_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // special function register port
  input  wire logic [7:0]                sfrAddr,
  input  wire logic                      sfrWrEn,
  input  wire logic [rsc_pkg::RSC_REG_W-1:0] sfrWrData,
  input  wire logic                      sfrRdEn,
  output logic      [rsc_pkg::RSC_REG_W-1:0] sfrRdData,
  // reset pin
  input  wire logic                      rstPinN,
  output logic                           rstPinOut,
  output logic                           rstPinOe,
  // power mode and clock monitor
  input  wire logic                      lowPowerMode,
  input  wire logic                      sysClkMon,
  // comparator
  input  wire logic                      cmpPlusBelowMinus,
  input  wire logic                      cmpWakeEnable,
  // watchdog
  input  wire logic                      wdtOverflow,
  input  wire logic                      wdtSwEnable,
  input  wire logic                      wdtSwDisable,
  output logic                           wdtEnable,
  output logic                           wdtTick,
  // flash access checks
  input  wire logic                      flashWriteEnable,
  input  wire logic                      flashWriteAboveLock,
  input  wire logic                      tableReadAboveLock,
  input  wire logic                      branchAboveLock,
  input  wire logic                      securityBlocked,
  input  wire logic                      flashWriteErase,
  input  wire logic                      supplyMonOn,
  // timekeeper
  input  wire logic                      rtcOscDetEnable,
  input  wire logic                      rtcOscSlow,
  input  wire logic                      rtcAlarmEnable,
  input  wire logic                      rtcAlarmMatch,
  // supply monitor
  input  wire logic                      supplyLow,
  input  wire logic                      supplyMonStable,
  // system reset
  output logic                           sysResetReq
);

  // ****************************************
  // state
  // ****************************************
  rsc_state_t             state_q;
  rsc_state_t             state_d;
  logic [3:0]             holdCnt_q;
  logic [RSC_REG_W-1:0]   causeFlags_q;
  logic [RSC_REG_W-1:0]   sfrRdData_q;
  logic                   mcdEn_q;
  logic                   cmpEn_q;
  logic                   rtcEn_q;
  logic                   supplyEn_q;
  logic                   wdtEnable_q;
  logic [3:0]             wdtDiv_q;
  logic                   wdtTick_q;
  logic                   sysResetReq_q;
  logic                   rstPinOut_q;
  logic                   rstPinOe_q;
  logic                   mcdTimeout;
  logic [RSC_REG_W-1:0]   causeVec;
  logic [RSC_REG_W-1:0]   readView;

  function automatic logic sfrHit(input logic [7:0] addr);
    sfrHit = (addr == RSC_CAUSE_ENABLE_ADDR);
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire running   = (state_q == RSC_RUN);
  wire regWrite  = sfrWrEn && sfrHit(sfrAddr) && running;
  wire regRead   = sfrRdEn && sfrHit(sfrAddr);
  wire mcdActive = mcdEn_q && !lowPowerMode && running;
  wire wdtActive = wdtEnable_q && !lowPowerMode;
  wire cmpActive = cmpEn_q && (!lowPowerMode || cmpWakeEnable);

  wire pinReq   = !rstPinN;
  wire porEarly = regWrite && sfrWrData[BIT_POR] && !supplyMonStable;
  wire porLevel = supplyLow && supplyEn_q;
  wire porReq   = porLevel || porEarly;
  wire mcdReq   = mcdTimeout && mcdActive;
  wire cmpReq   = cmpActive && cmpPlusBelowMinus;
  wire wdtReq   = wdtOverflow && wdtActive;
  wire flashReq = (flashWriteEnable && flashWriteAboveLock) || tableReadAboveLock
                  || branchAboveLock || securityBlocked
                  || (flashWriteErase && !supplyMonOn);
  wire rtcReq   = rtcEn_q && ((rtcOscDetEnable && rtcOscSlow)
                  || (rtcAlarmEnable && rtcAlarmMatch));
  wire swReq    = regWrite && sfrWrData[BIT_SW];

  assign causeVec[BIT_PIN]   = pinReq;
  assign causeVec[BIT_POR]   = porReq;
  assign causeVec[BIT_MCD]   = mcdReq;
  assign causeVec[BIT_WDT]   = wdtReq;
  assign causeVec[BIT_SW]    = swReq;
  assign causeVec[BIT_CMP]   = cmpReq;
  assign causeVec[BIT_FLASH] = flashReq;
  assign causeVec[BIT_RTC]   = rtcReq;

  wire anyCause  = |causeVec;
  wire levelHold = pinReq || porLevel || cmpReq;
  wire holdDone  = (holdCnt_q >= RESET_HOLD_CYCLES - CNT_ONE) && !levelHold;
  wire exitReset = (state_q == RSC_HOLD) && holdDone;
  wire wdtWrap   = (wdtDiv_q == WDT_CLK_DIV - CNT_ONE);

  genvar g;
  generate
    for (g = 0; g < RSC_REG_W; g++)
    begin : g_view
      if (g == BIT_POR)
      begin : g_por
        assign readView[g] = causeFlags_q[g];
      end
      else
      begin : g_other
        assign readView[g] = causeFlags_q[g] && !causeFlags_q[BIT_POR];
      end
    end
  endgenerate

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RSC_RUN:
        if (anyCause)
          state_d = RSC_HOLD;
      RSC_HOLD:
        if (holdDone)
          state_d = RSC_RUN;
      default:
        state_d = RSC_HOLD;
    endcase
  end

  // ****************************************
  // clock loss one-shot
  // ****************************************
  rsc_clock_loss_detector u_clock_loss (
    .clk       (clk),
    .resetn    (resetn),
    .enable    (mcdActive),
    .sysClkMon (sysClkMon),
    .timeout   (mcdTimeout)
  );

  // ****************************************
  // sequencer and cause flags
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q       <= RSC_HOLD;
      holdCnt_q     <= CNT_ZERO;
      causeFlags_q  <= FLAGS_POWER_ON;
      sysResetReq_q <= 1'b1;
    end
    else
    begin
      state_q       <= state_d;
      sysResetReq_q <= (state_d == RSC_HOLD);
      if (state_q == RSC_RUN)
        holdCnt_q <= CNT_ZERO;
      else if (!holdDone)
        holdCnt_q <= holdCnt_q + CNT_ONE;
      if (running && anyCause)
        causeFlags_q <= causeVec;
    end
  end

  // ****************************************
  // enables
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mcdEn_q    <= 1'b0;
      cmpEn_q    <= 1'b0;
      rtcEn_q    <= 1'b0;
      supplyEn_q <= 1'b1;
    end
    else if (exitReset)
    begin
      mcdEn_q <= 1'b0;
      cmpEn_q <= 1'b0;
      rtcEn_q <= 1'b0;
    end
    else if (regWrite)
    begin
      mcdEn_q    <= sfrWrData[BIT_MCD];
      cmpEn_q    <= sfrWrData[BIT_CMP];
      rtcEn_q    <= sfrWrData[BIT_RTC];
      supplyEn_q <= sfrWrData[BIT_POR];
    end
  end

  // ****************************************
  // watchdog enable and divider
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdtEnable_q <= 1'b1;
      wdtDiv_q    <= CNT_ZERO;
      wdtTick_q   <= 1'b0;
    end
    else
    begin
      if (exitReset || sysResetReq_q)
        wdtEnable_q <= 1'b1;
      else if (wdtSwDisable)
        wdtEnable_q <= 1'b0;
      else if (wdtSwEnable)
        wdtEnable_q <= 1'b1;
      wdtDiv_q  <= wdtWrap ? CNT_ZERO : wdtDiv_q + CNT_ONE;
      wdtTick_q <= wdtWrap;
    end
  end

  // ****************************************
  // read port and pin
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sfrRdData_q <= FLAGS_NONE;
      rstPinOut_q <= 1'b0;
      rstPinOe_q  <= 1'b0;
    end
    else
    begin
      sfrRdData_q <= regRead ? readView : FLAGS_NONE;
      rstPinOut_q <= 1'b0;
      rstPinOe_q  <= 1'b0;
    end
  end

  assign sfrRdData   = sfrRdData_q;
  assign rstPinOut   = rstPinOut_q;
  assign rstPinOe    = rstPinOe_q;
  assign wdtEnable   = wdtEnable_q;
  assign wdtTick     = wdtTick_q;
  assign sysResetReq = sysResetReq_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_enter;
    running ##0 anyCause;
  endsequence

  sequence s_in_reset;
    sysResetReq_q && (state_q == RSC_HOLD);
  endsequence

  property p_pin_reset;
    !rstPinN |=> s_in_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low without reset");

  property p_pin_flag;
    (running && !rstPinN) |=> causeFlags_q[BIT_PIN] ##1 (sysResetReq_q || causeFlags_q[BIT_PIN]);
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");

  property p_mcd_reset;
    (mcdTimeout && mcdEn_q && !lowPowerMode && running) |=> s_in_reset ##0 causeFlags_q[BIT_MCD];
  endproperty
  a_mcd_reset: assert property (p_mcd_reset) else $error("clock loss not reset");

  property p_mcd_enable_write;
    (regWrite && !anyCause && !exitReset) |=> (mcdEn_q == $past(sfrWrData[BIT_MCD]));
  endproperty
  a_mcd_enable_write: assert property (p_mcd_enable_write) else $error("enable not stored");

  property p_mcd_masked;
    lowPowerMode && !regWrite && running |=> !mcdReq && $stable(mcdEn_q);
  endproperty
  a_mcd_masked: assert property (p_mcd_masked) else $error("clock loss active in low power");

  property p_pin_free;
    s_in_reset |-> (!rstPinOe_q && !rstPinOut_q) [*2];
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("reset pin driven");

  property p_cmp_hold;
    (sysResetReq_q && cmpReq) |=> sysResetReq_q;
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("comparator hold released");

  property p_cmp_sleep;
    (lowPowerMode && !cmpWakeEnable) |-> !causeVec[BIT_CMP];
  endproperty
  a_cmp_sleep: assert property (p_cmp_sleep) else $error("comparator reset in low power");

  property p_wdt_tick;
    wdtTick_q |=> (!wdtTick_q) [*8] ##1 (!wdtTick_q) [*3] ##1 wdtTick_q;
  endproperty
  a_wdt_tick: assert property (p_wdt_tick) else $error("watchdog tick not every 12");

  property p_wdt_flag;
    (running && wdtOverflow && wdtEnable_q && !lowPowerMode) |=> causeFlags_q[BIT_WDT];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

  property p_flash_flag;
    (running && flashReq) |=> s_in_reset ##0 causeFlags_q[BIT_FLASH];
  endproperty
  a_flash_flag: assert property (p_flash_flag) else $error("flash fault not recorded");

  property p_rtc_sleep;
    (running && rtcEn_q && rtcAlarmEnable && rtcAlarmMatch) |=> causeFlags_q[BIT_RTC];
  endproperty
  a_rtc_sleep: assert property (p_rtc_sleep) else $error("timekeeper reset lost");

  property p_sw_reset;
    swReq |=> s_in_reset ##0 causeFlags_q[BIT_SW];
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("forced reset missing");

  property p_por_view;
    (regRead && causeFlags_q[BIT_POR]) |=> (sfrRdData_q == FLAGS_POWER_ON);
  endproperty
  a_por_view: assert property (p_por_view) else $error("power flag read wrong");

  property p_latest_cause;
    s_enter |=> (causeFlags_q == $past(causeVec));
  endproperty
  a_latest_cause: assert property (p_latest_cause) else $error("stale cause flags");

endmodule

// ---- tb/rsc_pin_driver.sv ----
/*
  partner model: external reset circuitry on the reset pin.
  assumes an external pull-up; press asks for a low pulse of PRESS clocks.
*/
`timescale 1ns/1ps
module rsc_pin_driver #(
  parameter int PRESS = 6
)(
  // clock
  input  wire logic clk,
  // request and device side of the pin
  input  wire logic press,
  input  wire logic devOut,
  input  wire logic devOe,
  // resolved pin level
  output logic      pinN
);
  // ****************************************
  // low pulse then pull-up
  // ****************************************
  logic [7:0] pressCnt_q = 8'h00;

  always_ff @(posedge clk)
    if (press)
      pressCnt_q <= 8'(PRESS);
    else if (pressCnt_q != 8'h00)
      pressCnt_q <= pressCnt_q - 8'h01;

  // pull-up wins when nobody drives
  assign pinN = devOe ? devOut : (pressCnt_q == 8'h00);
endmodule

// ---- tb/rsc_reset_source_controller_tb.sv ----
/*
  self-checking bench of the reset source controller.
  assumes rsc_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
module rsc_reset_source_controller_tb;
  import rsc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic       clk, resetn, sfrWrEn, sfrRdEn, rstPinN, rstPinOut, rstPinOe;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData;
  logic       lowPowerMode, sysClkMon, clkRun, cmpPlusBelowMinus, cmpWakeEnable;
  logic       wdtOverflow, wdtSwEnable, wdtSwDisable, wdtEnable, wdtTick;
  logic       flashWriteEnable, flashWriteAboveLock, tableReadAboveLock;
  logic       branchAboveLock, securityBlocked, flashWriteErase, supplyMonOn;
  logic       rtcOscDetEnable, rtcOscSlow, rtcAlarmEnable, rtcAlarmMatch;
  logic       supplyLow, supplyMonStable, sysResetReq, press;
  int         failures = 0;
  int         checks = 0;

  rsc_reset_source_controller dut_u (
    .clk(clk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .rstPinN(rstPinN), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .lowPowerMode(lowPowerMode), .sysClkMon(sysClkMon),
    .cmpPlusBelowMinus(cmpPlusBelowMinus), .cmpWakeEnable(cmpWakeEnable),
    .wdtOverflow(wdtOverflow), .wdtSwEnable(wdtSwEnable),
    .wdtSwDisable(wdtSwDisable), .wdtEnable(wdtEnable), .wdtTick(wdtTick),
    .flashWriteEnable(flashWriteEnable), .flashWriteAboveLock(flashWriteAboveLock),
    .tableReadAboveLock(tableReadAboveLock), .branchAboveLock(branchAboveLock),
    .securityBlocked(securityBlocked), .flashWriteErase(flashWriteErase),
    .supplyMonOn(supplyMonOn), .rtcOscDetEnable(rtcOscDetEnable),
    .rtcOscSlow(rtcOscSlow), .rtcAlarmEnable(rtcAlarmEnable),
    .rtcAlarmMatch(rtcAlarmMatch), .supplyLow(supplyLow),
    .supplyMonStable(supplyMonStable), .sysResetReq(sysResetReq));

  rsc_pin_driver #(.PRESS(6)) pin_u (
    .clk(clk), .press(press), .devOut(rstPinOut), .devOe(rstPinOe), .pinN(rstPinN));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
    if (clkRun)
      sysClkMon <= ~sysClkMon;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic give_verdict;
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bad(input string m);
    failures++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp)
      bad(m);
  endtask

  // bit1 always written as 1 to keep the power-fail reset
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    sfrAddr   <= 8'hEF;
    sfrWrData <= d | 8'h02;
    sfrWrEn   <= 1'b1;
    @(posedge clk);
    sfrWrEn   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(posedge clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk);
    sfrRdEn <= 1'b0;
    #1;
    chk(sfrRdData, exp, m);
  endtask

  task automatic waitrst(input logic lvl, input int lim, output int n);
    n = 0;
    while (sysResetReq !== lvl && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic endrst(input logic [7:0] exp, input string m);
    int n;
    chk({7'h00, rstPinOe}, 8'h00, "pin driven by device");
    waitrst(1'b0, 200, n);
    chk(8'(n == 200), 8'h00, "reset never released");
    rd(8'hEF, exp, m);
  endtask

  task automatic expect_rst(input int lo, input int hi, input logic [7:0] exp,
                            input string m);
    int n;
    waitrst(1'b1, hi, n);
    chk(8'(n >= lo && n < hi), 8'h01, m);
    endrst(exp, m);
  endtask

  task automatic norst(input int lim, input string m);
    int n;
    waitrst(1'b1, lim, n);
    chk(8'(n == lim), 8'h01, m);
  endtask

  task automatic wdtcfg(input logic en, input logic dis, input logic [7:0] exp);
    @(posedge clk);
    wdtSwEnable  <= en;
    wdtSwDisable <= dis;
    @(posedge clk);
    wdtSwEnable  <= 1'b0;
    wdtSwDisable <= 1'b0;
    #1;
    chk({7'h00, wdtEnable}, exp, "watchdog config");
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_por;
    int n;
    endrst(8'h02, "power-on flags");
    chk({7'h00, wdtEnable}, 8'h01, "watchdog not enabled");
    n = 0;
    while (wdtTick !== 1'b1 && n < 30)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (wdtTick !== 1'b1 && n < 30);
    chk(8'(n), 8'h0C, "tick spacing");
  endtask

  task automatic t_sw;
    wdtcfg(1'b0, 1'b1, 8'h00);
    wdtcfg(1'b1, 1'b0, 8'h01);
    wdtcfg(1'b1, 1'b1, 8'h00);
    wr(8'h10);
    expect_rst(0, 5, 8'h10, "forced reset");
    chk({7'h00, wdtEnable}, 8'h01, "watchdog after reset");
  endtask

  task automatic t_pin;
    @(posedge clk);
    lowPowerMode <= 1'b1;
    press        <= 1'b1;
    @(posedge clk);
    press        <= 1'b0;
    expect_rst(0, 5, 8'h01, "pin reset");
    @(posedge clk);
    lowPowerMode <= 1'b0;
    wr(8'hC9);
    norst(6, "read-modify-write reset");
    rd(8'hEF, 8'h01, "flags after rmw");
  endtask

  task automatic t_wdt;
    @(posedge clk);
    lowPowerMode <= 1'b1;
    wdtOverflow  <= 1'b1;
    @(posedge clk);
    wdtOverflow  <= 1'b0;
    lowPowerMode <= 1'b0;
    norst(5, "watchdog in low power");
    @(posedge clk);
    wdtOverflow  <= 1'b1;
    @(posedge clk);
    wdtOverflow  <= 1'b0;
    expect_rst(0, 5, 8'h40 >> 3, "watchdog reset");
  endtask

  task automatic t_flash;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      flashWriteEnable    <= (k == 0);
      flashWriteAboveLock <= (k == 0 || k == 5);
      tableReadAboveLock  <= (k == 1);
      branchAboveLock     <= (k == 2);
      securityBlocked     <= (k == 3);
      supplyMonOn         <= (k != 4);
      flashWriteErase     <= (k == 4);
      @(posedge clk);
      {flashWriteEnable, flashWriteAboveLock, tableReadAboveLock} <= 3'h0;
      {branchAboveLock, securityBlocked, flashWriteErase} <= 3'h0;
      supplyMonOn         <= 1'b1;
      if (k == 5)
        norst(5, "write above lock while disabled");
      else
        expect_rst(0, 5, 8'h40, "flash fault");
    end
  endtask

  task automatic t_cmp;
    // comparator output settled low before enabling
    wr(8'h20);
    @(posedge clk);
    lowPowerMode      <= 1'b1;
    cmpPlusBelowMinus <= 1'b1;
    norst(5, "comparator in low power without wake");
    @(posedge clk);
    cmpWakeEnable     <= 1'b1;
    expect_hold();
  endtask

  task automatic expect_hold;
    int n;
    waitrst(1'b1, 5, n);
    chk(8'(n < 5), 8'h01, "comparator reset with wake");
    repeat (10) @(posedge clk);
    #1;
    chk({7'h00, sysResetReq}, 8'h01, "comparator hold");
    @(posedge clk);
    cmpPlusBelowMinus <= 1'b0;
    cmpWakeEnable     <= 1'b0;
    lowPowerMode      <= 1'b0;
    endrst(8'h20, "comparator flag");
  endtask

  task automatic t_rtc;
    for (int j = 0; j < 2; j++)
    begin
      wr(8'h80);
      @(posedge clk);
      lowPowerMode    <= 1'b1;
      rtcOscDetEnable <= (j == 0);
      rtcOscSlow      <= (j == 0);
      rtcAlarmEnable  <= (j == 1);
      rtcAlarmMatch   <= (j == 1);
      @(posedge clk);
      {rtcOscDetEnable, rtcOscSlow, rtcAlarmEnable, rtcAlarmMatch} <= 4'h0;
      lowPowerMode    <= 1'b0;
      expect_rst(0, 5, 8'h80, "timekeeper reset");
    end
  endtask

  task automatic t_mcd;
    wr(8'h04);
    clkRun <= 1'b0;
    expect_rst(2400, 2600, 8'h04, "clock loss timing");
    clkRun <= 1'b1;
    wr(8'h04);
    @(posedge clk);
    lowPowerMode <= 1'b1;
    clkRun       <= 1'b0;
    norst(2700, "clock loss in low power");
    @(posedge clk);
    lowPowerMode <= 1'b0;
    expect_rst(0, 2600, 8'h04, "clock loss restored");
    clkRun <= 1'b1;
  endtask

  task automatic t_sup;
    int n;
    @(posedge clk);
    press     <= 1'b1;
    @(posedge clk);
    press     <= 1'b0;
    supplyLow <= 1'b1;
    waitrst(1'b1, 5, n);
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, sysResetReq}, 8'h01, "supply hold");
    @(posedge clk);
    supplyLow <= 1'b0;
    endrst(8'h02, "supply and pin flags masked");
    @(posedge clk);
    supplyMonStable <= 1'b0;
    wr(8'h02);
    expect_rst(0, 5, 8'h02, "unstable monitor enable");
    @(posedge clk);
    supplyMonStable <= 1'b1;
    rd(8'hEE, 8'h00, "unmapped read");
  endtask

  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial
  begin
    {resetn, sfrWrEn, sfrRdEn, lowPowerMode, sysClkMon, press} = 6'h00;
    {cmpPlusBelowMinus, cmpWakeEnable, wdtOverflow, wdtSwEnable} = 4'h0;
    {wdtSwDisable, flashWriteEnable, flashWriteAboveLock} = 3'h0;
    {tableReadAboveLock, branchAboveLock, securityBlocked, flashWriteErase} = 4'h0;
    {rtcOscDetEnable, rtcOscSlow, rtcAlarmEnable, rtcAlarmMatch, supplyLow} = 5'h00;
    {supplyMonOn, supplyMonStable, clkRun} = 3'h7;
    sfrAddr   = 8'h00;
    sfrWrData = 8'h00;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_por();
    t_sw();
    t_pin();
    t_wdt();
    t_flash();
    t_cmp();
    t_rtc();
    t_mcd();
    t_sup();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad("timeout");
    give_verdict();
  end
endmodule
